// *** src/led_exec_pkg.sv ***
// constants shared by the led engine execution block
package led_exec_pkg;
  // clock figures
  localparam int CLK_HZ = 200_000_000;
  localparam int MASTER_HZ = 32_768;
  localparam int MASTER_DIV = CLK_HZ / MASTER_HZ;
  localparam int DIV_FAST = 16;
  localparam int DIV_SLOW = 512;
  localparam int DIV_W = 9;
  localparam logic [4:0] FIXED_UNITS = 5'h01;
  // sizes
  localparam int CHANNELS = 9;
  localparam int DUTY_W = 8;
  localparam int ROWS = 96;
  localparam int ROW_W = 7;
  localparam int ADDR_W = 12;
  // register byte offsets
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_VAR_A = 12'h008;
  localparam logic [11:0] OFS_VAR_B = 12'h00C;
  localparam logic [11:0] OFS_VAR_C = 12'h010;
  localparam logic [11:0] OFS_VAR_D = 12'h014;
  localparam logic [11:0] OFS_CTRL = 12'h018;
  localparam logic [11:0] OFS_ENGINE = 12'h01C;
  localparam logic [11:0] OFS_DUTY0 = 12'h040;
  localparam logic [11:0] OFS_MAP0 = 12'h100;
  localparam logic [11:0] OFS_MAP_LAST = 12'h27C;
  // command word fields
  localparam int OP_LSB = 16;
  localparam int OP_MSB = 19;
  localparam int PRESCALE_BIT = 14;
  localparam int STEP_MSB = 13;
  localparam int STEP_LSB = 9;
  localparam int SIGN_BIT = 8;
  localparam int VALUE_MSB = 7;
  localparam int SEL2_MSB = 3;
  localparam int SEL2_LSB = 2;
  localparam int SEL1_MSB = 1;
  localparam int LED_SEL_MSB = 3;
  // opcodes
  localparam logic [3:0] OP_RAMP_IMM = 4'h0;
  localparam logic [3:0] OP_RAMP_VAR = 4'h1;
  localparam logic [3:0] OP_DUTY_IMM = 4'h2;
  localparam logic [3:0] OP_DUTY_VAR = 4'h3;
  localparam logic [3:0] OP_WAIT = 4'h4;
  localparam logic [3:0] OP_FIRST_LOAD = 4'h5;
  localparam logic [3:0] OP_MAP_START = 4'h6;
  localparam logic [3:0] OP_LAST_LOAD = 4'h7;
  localparam logic [3:0] OP_SELECT = 4'h8;
  localparam logic [3:0] OP_CLEAR = 4'h9;
  localparam logic [3:0] OP_MAP_NEXT = 4'hA;
  localparam logic [3:0] OP_FOLLOW = 4'hB;
  // variable selector codes
  localparam logic [1:0] VSEL_A = 2'h0;
  localparam logic [1:0] VSEL_B = 2'h1;
  localparam logic [1:0] VSEL_C = 2'h2;
  // status and control bits
  localparam int ST_BUSY = 0;
  localparam int ST_WAIT = 1;
  localparam int ST_RAMP = 2;
  localparam int ST_ROW_LSB = 8;
  localparam int ST_PTR_LSB = 16;
  localparam int CTRL_D_FROM_TEST = 0;
  localparam logic [7:0] DUTY_MAX = 8'hFF;
  localparam logic [7:0] DUTY_MIN = 8'h00;
endpackage

// *** src/master_tick_gen.sv ***
// divides the system clock down to master clock ticks
`timescale 1ns/1ps
`default_nettype none
module master_tick_gen #(
  parameter int DIV = led_exec_pkg::MASTER_DIV
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [15:0] count;

  // free running divider, one pulse per master period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (count == 16'(DIV - 1)) begin
      count <= 16'h0000;
      tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** src/prescale_timer.sv ***
// counts a number of prescaled cycles and pulses when done
`timescale 1ns/1ps
`default_nettype none
module prescale_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic masterTick,
  input wire logic start,
  input wire logic slow,
  input wire logic [4:0] units,
  output logic done
);
  logic [8:0] divCount;
  logic [4:0] unitsLeft;
  logic running;
  logic [8:0] divLast;

  // slow cycle is 512 master ticks, fast one is 16
  assign divLast = slow ? 9'(led_exec_pkg::DIV_SLOW - 1)
                        : 9'(led_exec_pkg::DIV_FAST - 1);

  // unit and divider counting, restarted at every start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCount <= 9'h000;
      unitsLeft <= 5'h00;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        divCount <= 9'h000;
        unitsLeft <= (units == 5'h00) ? 5'h01 : units;
        running <= 1'b1;
      end else if (running && masterTick) begin
        if (divCount == divLast) begin
          divCount <= 9'h000;
          if (unitsLeft == 5'h01) begin
            running <= 1'b0;
            done <= 1'b1;
          end else begin
            unitsLeft <= unitsLeft - 5'h01;
          end
        end else begin
          divCount <= divCount + 9'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** src/led_engine_exec.sv ***
// one program engine: ramp, duty set, wait and mapping execution
//
// Operation
// RQ1: variable step time uses low five bits
// RQ2: selector picks A, B, C or D/test
// RQ3: program keeps step time 1 to 31
// RQ4: step count 0-255; zero is a wait
// RQ5: variable step count from selected variable
// RQ6: step lasts step time times prescale cycle
// RQ7: duty set loads value immediately, no ramp
// RQ8: duty set takes sixteen master cycles
// RQ9: duty 0-255 linear, immediate or variable
// RQ10: wait holds outputs, shows wait status
// RQ11: prescale picks divide by 16 or 512
// RQ12: wait lasts time field times cycle
// RQ13: engine drives any subset of nine channels
// RQ14: table first and last rows recorded
// RQ15: map start records and activates row
// RQ16: select connects one driver, zero none
// RQ17: clear unmaps; unmapped keep stored duty
// RQ18: map next advances, wraps to start
// RQ19: row change never pushes duty values
// RQ20: pointer step changes no connections
// RQ21: each ramp step moves duty by one
// RQ22: ramp saturates but runs all steps
// RQ23: variable operands captured at ramp start
`timescale 1ns/1ps
`default_nettype none
module led_engine_exec #(
  parameter int MASTER_DIV = led_exec_pkg::MASTER_DIV,
  parameter int CHANNELS = led_exec_pkg::CHANNELS,
  parameter int ROWS = led_exec_pkg::ROWS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [7:0] testConverterResult,
  output logic [CHANNELS-1:0][7:0] ledChannelOutputs,
  output logic engineBusy
);
  typedef enum logic [1:0] {IDLE, HOLD, RAMP, WAIT} state_t;

  state_t state;
  logic [7:0] varA, varB, varC, varD;
  logic dFromTest;
  logic [7:0] engineDuty;
  logic [CHANNELS-1:0] mappedMask;
  logic [6:0] tableFirstRow, tableLastRow, pointer;
  logic [CHANNELS-1:0] mapRows [ROWS];
  logic [7:0] rampLeft;
  logic rampDown;
  logic timerStart, timerSlow, timerDone, masterTick;
  logic [4:0] timerUnits;
  logic [31:0] readData;
  logic addrHit, accessWr, cmdWr, pushEn;
  logic [7:0] pushVal;
  logic [3:0] cmdOp;
  logic [6:0] cmdRow, followRow;
  logic [7:0] selA, selB;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // map table window test
  function automatic logic isMapAddr(input logic [11:0] a);
    return a >= led_exec_pkg::OFS_MAP0 && a <= led_exec_pkg::OFS_MAP_LAST;
  endfunction

  // word index within a region
  function automatic logic [6:0] wordIndex(input logic [11:0] a,
                                           input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[8:2];
  endfunction

  // operand source selection
  function automatic logic [7:0] pickVar(input logic [1:0] sel);
    case (sel)
      led_exec_pkg::VSEL_A: return varA;
      led_exec_pkg::VSEL_B: return varB;
      led_exec_pkg::VSEL_C: return varC;
      default: return dFromTest ? testConverterResult : varD;
    endcase
  endfunction

  // saturating one unit step
  function automatic logic [7:0] stepDuty(input logic [7:0] v,
                                          input logic down);
    if (down) begin
      return (v == led_exec_pkg::DUTY_MIN) ? v : v - 8'h01;
    end
    return (v == led_exec_pkg::DUTY_MAX) ? v : v + 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // timing

  master_tick_gen #(.DIV(MASTER_DIV)) tickGen (
    .clk(clk),
    .rst(rst),
    .tick(masterTick)
  );

  prescale_timer stepTimer (
    .clk(clk),
    .rst(rst),
    .masterTick(masterTick),
    .start(timerStart),
    .slow(timerSlow),
    .units(timerUnits),
    .done(timerDone)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb slave

  // address decode
  always_comb begin
    addrHit = 1'b1;
    readData = 32'h0000_0000;
    case (paddr)
      led_exec_pkg::OFS_CMD: readData = 32'h0000_0000;
      led_exec_pkg::OFS_STATUS: begin
        readData[led_exec_pkg::ST_BUSY] = state != IDLE;
        readData[led_exec_pkg::ST_WAIT] = state == WAIT;
        readData[led_exec_pkg::ST_RAMP] = state == RAMP;
        readData[led_exec_pkg::ST_ROW_LSB +: 7] = tableFirstRow;
        readData[led_exec_pkg::ST_PTR_LSB +: 7] = pointer;
      end
      led_exec_pkg::OFS_VAR_A: readData[7:0] = varA;
      led_exec_pkg::OFS_VAR_B: readData[7:0] = varB;
      led_exec_pkg::OFS_VAR_C: readData[7:0] = varC;
      led_exec_pkg::OFS_VAR_D: readData[7:0] = varD;
      led_exec_pkg::OFS_CTRL: begin
        readData[led_exec_pkg::CTRL_D_FROM_TEST] = dFromTest;
      end
      led_exec_pkg::OFS_ENGINE: begin
        readData[7:0] = engineDuty;
        readData[16 +: CHANNELS] = mappedMask;
      end
      default: begin
        if (isMapAddr(paddr)) begin
          readData[CHANNELS-1:0] = mapRows[wordIndex(paddr,
                                     led_exec_pkg::OFS_MAP0)];
        end else if (paddr >= led_exec_pkg::OFS_DUTY0 &&
                     paddr < led_exec_pkg::OFS_DUTY0 +
                             12'(4 * CHANNELS) &&
                     paddr[1:0] == 2'h0) begin
          readData[7:0] = ledChannelOutputs[wordIndex(paddr,
                            led_exec_pkg::OFS_DUTY0)];
        end else begin
          addrHit = 1'b0;
        end
      end
    endcase
    if (paddr[1:0] != 2'h0) begin
      addrHit = 1'b0;
    end
  end

  assign accessWr = psel && penable && pready && pwrite && addrHit;

  // no wait state: data captured in the setup cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrHit;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : readData;
      end
    end
  end

  // software variables and control bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      varA <= 8'h00;
      varB <= 8'h00;
      varC <= 8'h00;
      varD <= 8'h00;
      dFromTest <= 1'b0;
    end else if (accessWr) begin
      case (paddr)
        led_exec_pkg::OFS_VAR_A: varA <= pwdata[7:0];
        led_exec_pkg::OFS_VAR_B: varB <= pwdata[7:0];
        led_exec_pkg::OFS_VAR_C: varC <= pwdata[7:0];
        led_exec_pkg::OFS_VAR_D: varD <= pwdata[7:0];
        led_exec_pkg::OFS_CTRL: begin
          dFromTest <= pwdata[led_exec_pkg::CTRL_D_FROM_TEST];
        end
        default: dFromTest <= dFromTest;
      endcase
    end
  end

  // mapping rows live in a local array, written over apb
  always_ff @(posedge clk) begin
    if (accessWr && isMapAddr(paddr)) begin
      mapRows[wordIndex(paddr, led_exec_pkg::OFS_MAP0)] <=
        pwdata[CHANNELS-1:0]; // RQ13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode

  assign cmdOp = pwdata[led_exec_pkg::OP_MSB:led_exec_pkg::OP_LSB];
  assign cmdRow = pwdata[6:0];
  assign cmdWr = accessWr && paddr == led_exec_pkg::OFS_CMD &&
                 state == IDLE;
  always_comb begin
    selA = pickVar(pwdata[led_exec_pkg::SEL1_MSB:0]); // RQ2
    selB = pickVar(pwdata[led_exec_pkg::SEL2_MSB:
                          led_exec_pkg::SEL2_LSB]); // RQ2
  end
  assign followRow = (pointer == tableLastRow) ? tableFirstRow
                                               : pointer + 7'h01; // RQ18

  // duty pushed to mapped channels: duty set or a live ramp step
  always_comb begin
    pushEn = 1'b0;
    pushVal = engineDuty;
    if (cmdWr && cmdOp == led_exec_pkg::OP_DUTY_IMM) begin
      pushEn = 1'b1;
      pushVal = pwdata[led_exec_pkg::VALUE_MSB:0]; // RQ7
    end else if (cmdWr && cmdOp == led_exec_pkg::OP_DUTY_VAR) begin
      pushEn = 1'b1;
      pushVal = selA; // RQ9
    end else if (state == RAMP && timerDone && rampLeft != 8'h00) begin
      pushEn = 1'b1;
      pushVal = stepDuty(engineDuty, rampDown); // RQ21 RQ22
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // execution state

  // instruction sequencing, timer loading and mapping state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= IDLE;
      engineDuty <= 8'h00;
      rampLeft <= 8'h00;
      rampDown <= 1'b0;
      timerStart <= 1'b0;
      timerSlow <= 1'b0;
      timerUnits <= 5'h00;
      mappedMask <= '0;
      tableFirstRow <= 7'h00;
      tableLastRow <= 7'h00;
      pointer <= 7'h00;
    end else begin
      timerStart <= 1'b0;
      if (pushEn) begin
        engineDuty <= pushVal;
      end
      case (state)
        IDLE: begin
          if (cmdWr) begin
            timerStart <= 1'b1;
            timerSlow <= 1'b0;
            timerUnits <= led_exec_pkg::FIXED_UNITS; // RQ8
            state <= HOLD;
            case (cmdOp)
              led_exec_pkg::OP_RAMP_IMM: begin
                timerSlow <= pwdata[led_exec_pkg::PRESCALE_BIT]; // RQ11
                timerUnits <= pwdata[led_exec_pkg::STEP_MSB:
                                     led_exec_pkg::STEP_LSB]; // RQ6
                rampDown <= pwdata[led_exec_pkg::SIGN_BIT];
                rampLeft <= pwdata[led_exec_pkg::VALUE_MSB:0]; // RQ4
                state <= RAMP;
              end
              led_exec_pkg::OP_RAMP_VAR: begin
                timerSlow <= pwdata[led_exec_pkg::PRESCALE_BIT];
                timerUnits <= selB[4:0]; // RQ1 RQ23
                rampDown <= pwdata[led_exec_pkg::SIGN_BIT];
                rampLeft <= selA; // RQ5 RQ23
                state <= RAMP;
              end
              led_exec_pkg::OP_WAIT: begin
                timerSlow <= pwdata[led_exec_pkg::PRESCALE_BIT]; // RQ11
                timerUnits <= pwdata[led_exec_pkg::STEP_MSB:
                                     led_exec_pkg::STEP_LSB]; // RQ12
                state <= WAIT; // RQ10
              end
              led_exec_pkg::OP_FIRST_LOAD: begin
                tableFirstRow <= cmdRow; // RQ14
              end
              led_exec_pkg::OP_LAST_LOAD: begin
                tableLastRow <= cmdRow; // RQ14
              end
              led_exec_pkg::OP_MAP_START: begin
                tableFirstRow <= cmdRow; // RQ15
                pointer <= cmdRow;
                mappedMask <= mapRows[cmdRow]; // RQ15 RQ19
              end
              led_exec_pkg::OP_SELECT: begin
                mappedMask <= '0; // RQ16
                if (pwdata[led_exec_pkg::LED_SEL_MSB:0] != 4'h0) begin
                  mappedMask[pwdata[led_exec_pkg::LED_SEL_MSB:0] -
                             4'h1] <= 1'b1; // RQ16
                end
              end
              led_exec_pkg::OP_CLEAR: mappedMask <= '0; // RQ17
              led_exec_pkg::OP_MAP_NEXT: begin
                pointer <= followRow; // RQ18
                mappedMask <= mapRows[followRow]; // RQ19
              end
              led_exec_pkg::OP_FOLLOW: pointer <= followRow; // RQ20
              default: state <= HOLD;
            endcase
          end
        end
        RAMP: begin
          if (timerDone) begin
            if (rampLeft > 8'h01) begin
              rampLeft <= rampLeft - 8'h01; // RQ22
              timerStart <= 1'b1;
            end else begin
              rampLeft <= 8'h00;
              state <= IDLE;
            end
          end
        end
        HOLD, WAIT: begin
          if (timerDone) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // channel duty registers; unmapped ones keep their value
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : gChan
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ledChannelOutputs[ch] <= 8'h00;
        end else if (pushEn && mappedMask[ch]) begin
          ledChannelOutputs[ch] <= pushVal; // RQ13 RQ17
        end else if (accessWr &&
                     paddr == led_exec_pkg::OFS_DUTY0 + 12'(4 * ch)) begin
          ledChannelOutputs[ch] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // busy flag out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      engineBusy <= 1'b0;
    end else begin
      engineBusy <= (state != IDLE) || cmdWr;
    end
  end
endmodule
`default_nettype wire

// *** testbench/led_exec_assertions.sv ***
// port checks for the led engine execution block
`timescale 1ns/1ps
`default_nettype none
module led_exec_assertions #(
  parameter int MASTER_DIV = 4,
  parameter int CHANNELS = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [7:0] testConverterResult,
  input wire logic [CHANNELS-1:0][7:0] ledChannelOutputs,
  input wire logic engineBusy
);
  logic apbWr;
  logic [15:0] busyLen;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // write access in progress
  assign apbWr = psel && penable && pwrite;
  // length of the current busy stretch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyLen <= 16'h0000;
    end else begin
      busyLen <= engineBusy ? busyLen + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error outside access");
  a_err_unmapped: assert property (psel && !penable && paddr == 12'hFF0
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_cmd_busy: assert property (
    apbWr && pready && paddr == 12'h000 && !engineBusy |-> ##[1:2] engineBusy)
    else $error("command did not start");
  a_busy_min_len: assert property (
    $fell(engineBusy) |-> busyLen >= 16'(15 * MASTER_DIV - 2))
    else $error("command ended too soon");
  a_busy_first_cycles: assert property (
    $rose(engineBusy) |-> engineBusy [*8])
    else $error("busy dropped early");
  a_outputs_frozen: assert property (
    $changed(ledChannelOutputs)
    |-> $past(engineBusy) || $past(engineBusy, 2) || $past(apbWr))
    else $error("duty changed while idle");
endmodule
bind led_engine_exec led_exec_assertions #(
  .MASTER_DIV(MASTER_DIV),
  .CHANNELS(CHANNELS)
) led_exec_assertions_inst (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr),
  .testConverterResult(testConverterResult),
  .ledChannelOutputs(ledChannelOutputs), .engineBusy(engineBusy)
);
`default_nettype wire

// *** testbench/led_channel_sink.sv ***
// far side: nine led drivers latching their duty values
`timescale 1ns/1ps
`default_nettype none
module led_channel_sink #(
  parameter int CHANNELS = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [CHANNELS-1:0][7:0] duty,
  output logic [31:0] changes
);
  logic [CHANNELS-1:0][7:0] held;
  // latch duty, count edges where any driver sees a new value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held <= '0;
      changes <= 32'h0000_0000;
    end else begin
      held <= duty;
      if (duty != held) begin
        changes <= changes + 32'h0000_0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the led engine execution block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DIV = 4;
  localparam int U = 16 * DIV;
  localparam logic [3:0] DUTY = led_exec_pkg::OP_DUTY_IMM;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, engineBusy, rde;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, changes, c0;
  logic [7:0] testConverterResult;
  logic [8:0][7:0] leds;
  logic [7:0] ex [9] = '{default: 8'h00};
  int err_total, compares, cyc;

  led_engine_exec #(.MASTER_DIV(DIV)) led_engine_exec_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr),
    .testConverterResult(testConverterResult),
    .ledChannelOutputs(leds), .engineBusy(engineBusy));
  led_channel_sink led_channel_sink_inst (
    .clk(clk), .rst(rst), .duty(leds), .changes(changes));

  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, x);
    compares++;
    if (s !== x) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic chkCh();
    for (int i = 0; i < 9; i++) begin
      chk("channel duty", 32'(leds[i]), 32'(ex[i]));
    end
  endtask
  // one apb transfer, result left in rdv and rde
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // wait for the engine to go idle and judge the duration
  task automatic idle(input int e);
    int d;
    d = 0;
    repeat (2) @(posedge clk);
    while (engineBusy === 1'b1) begin
      @(posedge clk);
      d++;
    end
    chk("duration", 32'(d >= e - 16 && d <= e + 6), 1);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [15:0] f, input int e);
    apb(1'b1, 12'h000, {12'h000, op, f});
    idle(e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_err();
    chkCh();
    apb(1'b0, 12'hFF0, 32'h0000_0000);
    chk("slverr", 32'(rde), 1);
    chk("rdata", rdv, 32'h0000_0000);
  endtask
  task automatic t_map();
    apb(1'b1, 12'h114, 32'h0000_0005);
    apb(1'b1, 12'h118, 32'h0000_0002);
    cmd(led_exec_pkg::OP_MAP_START, 16'h0005, U);
    cmd(led_exec_pkg::OP_LAST_LOAD, 16'h0006, U);
    cmd(DUTY, 16'h0080, U);
    ex[0] = 8'h80;
    ex[2] = 8'h80;
    chkCh();
    c0 = changes;
    cmd(led_exec_pkg::OP_MAP_NEXT, 16'h0000, U);
    chk("changes", changes, c0);
    cmd(DUTY, 16'h0010, U);
    ex[1] = 8'h10;
    chkCh();
    cmd(led_exec_pkg::OP_MAP_NEXT, 16'h0000, U);
    cmd(led_exec_pkg::OP_FOLLOW, 16'h0000, U);
    apb(1'b0, led_exec_pkg::OFS_STATUS, 32'h0000_0000);
    chk("rows", 32'({rdv[22:16], rdv[14:8]}), 32'h0000_0305);
    cmd(DUTY, 16'h0030, U);
    ex[0] = 8'h30;
    ex[2] = 8'h30;
    chkCh();
    cmd(led_exec_pkg::OP_FIRST_LOAD, 16'h0003, U);
    apb(1'b0, led_exec_pkg::OFS_STATUS, 32'h0000_0000);
    chk("first row", 32'(rdv[14:8]), 32'h0000_0003);
    chkCh();
  endtask
  task automatic t_select();
    for (int c = 0; c <= 9; c++) begin
      cmd(led_exec_pkg::OP_SELECT, 16'(c), U);
      cmd(DUTY, 16'(8'hA0 + c), U);
      if (c > 0) begin
        ex[c - 1] = 8'(8'hA0 + c);
      end
      chkCh();
    end
    cmd(led_exec_pkg::OP_CLEAR, 16'h0000, U);
    cmd(DUTY, 16'h0077, U);
    chkCh();
  endtask
  task automatic t_ramp();
    cmd(led_exec_pkg::OP_SELECT, 16'h0001, U);
    cmd(DUTY, 16'h00FD, U);
    c0 = changes;
    cmd(led_exec_pkg::OP_RAMP_IMM, 16'h0205, 5 * U);
    ex[0] = 8'hFF;
    chkCh();
    chk("steps", changes - c0, 2);
    cmd(led_exec_pkg::OP_RAMP_IMM, 16'h0500, 2 * U);
    chkCh();
  endtask
  task automatic t_vars();
    logic [7:0] v [4] = '{8'h00, 8'h5B, 8'hFF, 8'h44};
    apb(1'b1, led_exec_pkg::OFS_VAR_A, 32'h0000_0023);
    apb(1'b1, led_exec_pkg::OFS_VAR_B, 32'h0000_0004);
    c0 = changes;
    apb(1'b1, 12'h000, 32'h0001_0101);
    apb(1'b1, led_exec_pkg::OFS_VAR_A, 32'h0000_0001);
    apb(1'b1, led_exec_pkg::OFS_VAR_B, 32'h0000_0009);
    idle(12 * U);
    ex[0] = 8'hFB;
    chkCh();
    chk("steps", changes - c0, 4);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 12'h008 + 12'(4 * s), 32'(v[s]));
      cmd(led_exec_pkg::OP_DUTY_VAR, 16'(s), U);
      ex[0] = v[s];
      chkCh();
    end
    apb(1'b1, led_exec_pkg::OFS_CTRL, 32'h0000_0001);
    testConverterResult <= 8'h5A;
    cmd(led_exec_pkg::OP_DUTY_VAR, 16'h0003, U);
    ex[0] = 8'h5A;
    chkCh();
  endtask
  task automatic t_wait();
    c0 = changes;
    apb(1'b1, 12'h000, 32'h0004_4200);
    apb(1'b0, led_exec_pkg::OFS_STATUS, 32'h0000_0000);
    chk("wait flag", 32'(rdv[1]), 1);
    idle(32 * U);
    chk("changes", changes, c0);
    cmd(led_exec_pkg::OP_WAIT, 16'h0600, 3 * U);
    chkCh();
  endtask
  ////////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      test_done();
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    testConverterResult = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_err();
    t_map();
    t_select();
    t_ramp();
    t_vars();
    t_wait();
    test_done();
  end
endmodule
`default_nettype wire
